// [rtl/ptc_defs.vh]
// Constants for the program trace capture block: codes, fields and sizes.
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH
// ----------------------------------------------------------------------------
// Completion type codes
// ----------------------------------------------------------------------------
`define PTC_CODE_NONE       3'h0
`define PTC_CODE_PLAIN      3'h1
`define PTC_CODE_LOAD       3'h2
`define PTC_CODE_STORE      3'h3
`define PTC_CODE_PC_SYNC    3'h4
`define PTC_CODE_FLOW       3'h5
`define PTC_CODE_FLOW_LOAD  3'h6
`define PTC_CODE_FLOW_STORE 3'h7
// ----------------------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------------------
`define PTC_FEAT_PRESENT_BIT 0
`define PTC_TC2_SUBSET_LSB   5
`define PTC_TC2_SUBSET_MSB   6
// ----------------------------------------------------------------------------
// Trace subsets
// ----------------------------------------------------------------------------
`define PTC_SUBSET_NONE     2'h0
`define PTC_SUBSET_PC       2'h1
`define PTC_SUBSET_PC_ADDR  2'h2
`define PTC_SUBSET_PC_DATA  2'h3
// ----------------------------------------------------------------------------
// Probe pin widths and sizes
// ----------------------------------------------------------------------------
`define PTC_PINS_4          2'h0
`define PTC_PINS_8          2'h1
`define PTC_PINS_16         2'h2
`define PTC_SYNC_PERIOD     16'h0100
`define PTC_FIFO_DEPTH      8
`define PTC_MEM_DEPTH       64
`endif

// [rtl/ptc_fifo.v]
// Parameterised valid/ready FIFO built from flip-flops.
module ptc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,       // Core clock.
  input  wire             rst_b,     // Asynchronous reset, active low.
  input  wire             in_valid,  // Write request.
  output wire             in_ready,  // Space available.
  input  wire [WIDTH-1:0] in_data,   // Write word.
  output wire             out_valid, // Word available.
  input  wire             out_ready, // Drain side accepts.
  output wire [WIDTH-1:0] out_data   // Head word.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [rtl/ptc_serializer.v]
// Splits a trace word into probe-side nibbles, bytes or half-words.
`include "ptc_defs.vh"
module ptc_serializer #(
  parameter WIDTH = 32
) (
  input  wire             clk,        // Core clock.
  input  wire             rst_b,      // Asynchronous reset, active low.
  input  wire [1:0]       pin_sel,    // Probe pin count select.
  input  wire             word_valid, // Word offered.
  output wire             word_ready, // Word taken this cycle.
  input  wire [WIDTH-1:0] word_data,  // Word to send.
  output reg  [15:0]      probe_data, // Probe data pins.
  output reg              probe_valid // Probe data strobe.
);
  reg [WIDTH-1:0] shreg;
  reg [4:0]       left;
  reg [4:0]       slices;
  reg [15:0]      slice;

  always @* begin
    case (pin_sel)
      `PTC_PINS_8:  begin slices = 5'd4; slice = {8'h00, shreg[7:0]}; end
      `PTC_PINS_16: begin slices = 5'd2; slice = shreg[15:0]; end
      default:      begin slices = 5'd8; slice = {12'h000, shreg[3:0]}; end
    endcase
  end

  assign word_ready = (left == 5'd0);

  // Low slice first; the width follows pin_sel live and is not latched per word, only the data is held in shreg.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg       <= {WIDTH{1'b0}};
      left        <= 5'd0;
      probe_data  <= 16'h0000;
      probe_valid <= 1'b0;
    end else if (left != 5'd0) begin
      probe_data  <= slice;
      probe_valid <= 1'b1;
      left        <= left - 5'd1;
      case (pin_sel)
        `PTC_PINS_8:  shreg <= shreg >> 8;
        `PTC_PINS_16: shreg <= shreg >> 16;
        default:      shreg <= shreg >> 4;
      endcase
    end else begin
      probe_valid <= 1'b0;
      if (word_valid) begin
        shreg <= word_data;
        left  <= slices;
      end
    end
  end
endmodule

// [rtl/ptc_trace_core.v]
// Core-side trace generation with a trace control unit, trace memory and probe path.
//
// Function
// - A read-only preset flag at bit 0 of the feature flags word shows whether trace logic exists.
// - One of four trace subsets is chosen, but only codes and PC are traced; no subset adds load or store address or data.
// - The subset is read from bits 6:5 of the second trace control register together with the flag.
// - Trace control registers are written by the probe through the test port or by software via debug memory.
// - All trace goes to the trace control unit, which stores it on chip or sends it to the probe.
// - The probe trace data pin count is configurable to 4, 8 or 16.
// - On-chip trace memory has a configurable size and is read out through the test port after capture stops.
// - A PC value is sent only for statically unpredictable flow changes; taken branches are flagged apart.
// - Register jumps, exceptions and exception returns count as unpredictable; conditional branches do not.
// - PC bits 28:0 are also sent at a fixed interval and on synchronisation requests.
// - Once tracing runs, a valid three-bit completion code is given in every cycle.
// - Code 000 is given in any cycle where no instruction completes; while stall_active is high the code holds its last value instead.
// - Codes 001, 010, 011 and 100 mark plain, load, store and PC-sync completions.
// - Codes 101, 110 and 111 mark completions with a PC discontinuity, plain, load or store.
// - The first instruction of a basic block always takes a flow-change code, load or store variant as needed.
`include "ptc_defs.vh"
module ptc_trace_core #(
  parameter [1:0] IMPL_SUBSET = `PTC_SUBSET_PC_DATA,
  parameter       MEM_DEPTH   = `PTC_MEM_DEPTH,
  parameter       MEM_AW      = 6,
  parameter [15:0] SYNC_PERIOD = `PTC_SYNC_PERIOD
) (
  input  wire        clk,              // Core clock.
  input  wire        rst_b,            // Asynchronous reset, active low.
  input  wire        retire_valid,     // An instruction completes this cycle.
  input  wire        retire_killed,    // The completing instruction was killed.
  input  wire        retire_load,      // Completing instruction is a load.
  input  wire        retire_store,     // Completing instruction is a store.
  input  wire        retire_taken,     // A taken branch leads to this instruction.
  input  wire        retire_reg_jump,  // Follows register_jump or register_jump_link.
  input  wire        retire_cond,      // Follows a taken conditional branch.
  input  wire        retire_exc,       // First instruction of an exception handler.
  input  wire        retire_exception_return,      // Follows exception_return or debug_exception_return.
  input  wire        sync_request,     // Synchronisation period request.
  input  wire [31:0] retire_pc,        // PC of the completing instruction.
  input  wire        cfg_wr,           // Control write from test port or debug segment.
  input  wire [1:0]  cfg_addr,         // Control register select.
  input  wire [31:0] cfg_wdata,        // Control write data.
  input  wire        cfg_rd,           // Control read strobe.
  output reg  [31:0] cfg_rdata,        // Control read data.
  output reg  [31:0] feature_flags_word, // Feature flags word.
  output reg  [2:0]  completion_type_code, // Per-cycle completion code.
  output reg         stall_active,     // Stall request seen by the core.
  output reg  [15:0] probe_data,       // Probe trace data pins.
  output reg         probe_valid       // Probe data strobe.
);
  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  localparam [1:0] ADDR_CTRL  = 2'h0;
  localparam [1:0] ADDR_TC2   = 2'h1;
  localparam [1:0] ADDR_MEMRD = 2'h2;
  localparam [1:0] ADDR_STAT  = 2'h3;
  localparam       FW         = 35;

  reg         trace_on;
  reg         to_probe;
  reg  [1:0]  pin_sel;
  reg  [MEM_AW-1:0] rd_index;
  reg  [MEM_AW-1:0] wr_index;
  reg         mem_wrapped;
  reg  [31:0] trace_mem [0:MEM_DEPTH-1];
  reg  [15:0] sync_cnt;
  reg         stall_req;
  reg  [3:0]  fill;
  wire [3:0]  next_fill;
  wire        fifo_pop;
  reg  [2:0]  next_code;
  reg         next_pc_out;
  wire [31:0] second_trace_control_reg;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire        drain_ready;
  wire        ser_ready;
  wire [15:0] ser_data;
  wire        ser_valid;
  wire        mem_full;
  wire        flow;
  wire        pc_sync_due;

  assign second_trace_control_reg = {25'h0, IMPL_SUBSET, 5'h00};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trace_on  <= 1'b0;
      to_probe  <= 1'b0;
      pin_sel   <= `PTC_PINS_4;
      rd_index  <= {MEM_AW{1'b0}};
      cfg_rdata <= 32'h00000000;
    end else begin
      if (cfg_wr && cfg_addr == ADDR_CTRL) begin
        trace_on <= cfg_wdata[0] & (IMPL_SUBSET != `PTC_SUBSET_NONE);
        to_probe <= cfg_wdata[1];
        pin_sel  <= (cfg_wdata[3:2] == 2'h3) ? `PTC_PINS_16 : cfg_wdata[3:2];
      end
      if (cfg_wr && cfg_addr == ADDR_MEMRD) begin
        rd_index <= cfg_wdata[MEM_AW-1:0];
      end else if (cfg_rd && cfg_addr == ADDR_MEMRD && !trace_on) begin
        rd_index <= rd_index + 1'b1;
      end
      if (cfg_rd) begin
        case (cfg_addr)
          ADDR_CTRL:  cfg_rdata <= {28'h0, pin_sel, to_probe, trace_on};
          ADDR_TC2:   cfg_rdata <= second_trace_control_reg;
          // Memory reads only once capture has stopped; records still in the FIFO keep draining to memory after the stop.
          ADDR_MEMRD: cfg_rdata <= trace_on ? 32'h00000000 : trace_mem[rd_index];
          ADDR_STAT:  cfg_rdata <= {mem_wrapped, {(31-MEM_AW){1'b0}}, wr_index};
          default:    cfg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Feature flags
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      feature_flags_word <= 32'h00000000;
    end else begin
      feature_flags_word <= {31'h0, (IMPL_SUBSET != `PTC_SUBSET_NONE)};
    end
  end

  // --------------------------------------------------------------------------
  // Completion code generation
  // --------------------------------------------------------------------------
  assign flow = retire_taken | retire_reg_jump | retire_cond | retire_exc | retire_exception_return;
  assign pc_sync_due = (sync_cnt == 16'h0000) | sync_request;

  always @* begin
    next_code   = `PTC_CODE_NONE;
    next_pc_out = 1'b0;
    if (retire_valid && !retire_killed) begin
      if (flow) begin
        // Block heads always flag a flow change; only unpredictable targets carry the PC.
        next_pc_out = retire_reg_jump | retire_exc | retire_exception_return;
        if (retire_load) begin
          next_code = `PTC_CODE_FLOW_LOAD;
        end else if (retire_store) begin
          next_code = `PTC_CODE_FLOW_STORE;
        end else begin
          next_code = `PTC_CODE_FLOW;
        end
      end else if (retire_load) begin
        next_code = `PTC_CODE_LOAD;
      end else if (retire_store) begin
        next_code = `PTC_CODE_STORE;
      end else if (pc_sync_due) begin
        // Periodic sync is kept off loads, stores and branches.
        next_code   = `PTC_CODE_PC_SYNC;
        next_pc_out = 1'b1;
      end else begin
        next_code = `PTC_CODE_PLAIN;
      end
    end
  end

  // The stall is raised from the fill level the FIFO will have after this edge, so a record is
  // never offered to a full FIFO and nothing is lost.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_req            <= 1'b0;
      stall_active         <= 1'b0;
      fill                 <= 4'h0;
      completion_type_code <= `PTC_CODE_NONE;
      sync_cnt             <= 16'h0000;
    end else begin
      fill         <= next_fill;
      stall_req    <= (next_fill == 4'h8);
      stall_active <= (next_fill == 4'h8);
      if (!trace_on) begin
        completion_type_code <= `PTC_CODE_NONE;
        sync_cnt             <= SYNC_PERIOD;
      end else if (!stall_req) begin
        completion_type_code <= next_code;
        if (next_code == `PTC_CODE_PC_SYNC) begin
          sync_cnt <= SYNC_PERIOD;
        end else if (next_code == `PTC_CODE_PLAIN && sync_cnt != 16'h0000) begin
          sync_cnt <= sync_cnt - 16'h0001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trace record path: code and PC (zero when not sent) into the FIFO
  // --------------------------------------------------------------------------
  wire          rec_valid;
  wire [FW-1:0] rec_data;
  // Records held back while stalled stay at the core; the core must hold its retire inputs.
  assign rec_valid = trace_on & ~stall_req & (next_code != `PTC_CODE_NONE);
  assign rec_data  = {next_code, next_pc_out ? retire_pc : 32'h00000000};
  assign fifo_pop  = fifo_out_valid & drain_ready;
  assign next_fill = fill + {3'h0, rec_valid} - {3'h0, fifo_pop};

  ptc_fifo #(
    .WIDTH (FW),
    .DEPTH (`PTC_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rec_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rec_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  // --------------------------------------------------------------------------
  // Drain to on-chip memory or probe
  // --------------------------------------------------------------------------
  // On-chip memory stops at full instead of wrapping, so the oldest trace survives.
  assign mem_full    = mem_wrapped;
  assign drain_ready = to_probe ? ser_ready : ~mem_full;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_index    <= {MEM_AW{1'b0}};
      mem_wrapped <= 1'b0;
    end else if (cfg_wr && cfg_addr == ADDR_CTRL && cfg_wdata[0]) begin
      wr_index    <= {MEM_AW{1'b0}};
      mem_wrapped <= 1'b0;
    end else if (fifo_out_valid && !to_probe && !mem_full) begin
      wr_index <= wr_index + 1'b1;
      if (wr_index == MEM_DEPTH[MEM_AW-1:0] - 1'b1) begin
        mem_wrapped <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (fifo_out_valid && !to_probe && !mem_full) begin
      trace_mem[wr_index] <= {fifo_out_data[34:32], fifo_out_data[28:0]};
    end
  end

  ptc_serializer #(
    .WIDTH (32)
  ) u_ser (
    .clk         (clk),
    .rst_b       (rst_b),
    .pin_sel     (pin_sel),
    .word_valid  (fifo_out_valid & to_probe),
    .word_ready  (ser_ready),
    .word_data   ({fifo_out_data[34:32], fifo_out_data[28:0]}),
    .probe_data  (ser_data),
    .probe_valid (ser_valid)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      probe_data  <= 16'h0000;
      probe_valid <= 1'b0;
    end else begin
      probe_data  <= ser_data;
      probe_valid <= ser_valid;
    end
  end
endmodule

// [bench/ptc_trace_core_chk.sv]
// Port-level assertions for the program trace capture core.
module ptc_trace_core_chk #(
  parameter [1:0] IMPL_SUBSET = 2'h3
) (
  input wire        clk,                  // Core clock.
  input wire        rst_b,                // Reset, active low.
  input wire        retire_valid,         // Completion.
  input wire        retire_killed,        // Killed completion.
  input wire        retire_load,          // Load.
  input wire        retire_store,         // Store.
  input wire        retire_taken,         // Taken branch.
  input wire        retire_reg_jump,      // Register jump.
  input wire        retire_cond,          // Conditional branch.
  input wire        retire_exc,           // Exception entry.
  input wire        retire_exception_return,          // Exception return.
  input wire        sync_request,         // Sync request.
  input wire        cfg_rd,               // Read strobe.
  input wire [1:0]  cfg_addr,             // Register select.
  input wire [31:0] cfg_rdata,            // Read data.
  input wire [31:0] feature_flags_word,   // Feature flags.
  input wire [2:0]  completion_type_code, // Completion code.
  input wire        stall_active          // Stall level.
);
  timeunit 1ns;
  timeprecision 1ns;
  wire take  = retire_valid && !retire_killed && !stall_active;
  wire flow  = retire_taken | retire_reg_jump | retire_cond | retire_exc | retire_exception_return;
  wire plain = take && !flow && !retire_load && !retire_store;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_FEAT: assert property ($past(rst_b) |-> feature_flags_word == {31'h0, IMPL_SUBSET != 2'h0})
    else $error("feature flags word wrong");
  AST_NONE: assert property ((!retire_valid || retire_killed) && !stall_active |=> completion_type_code == 3'h0)
    else $error("idle code wrong");
  AST_FLOW: assert property (take && flow |=> completion_type_code ==
    ($past(retire_store) ? 3'h7 : $past(retire_load) ? 3'h6 : 3'h5)) else $error("flow code wrong");
  AST_LDST: assert property (take && !flow && (retire_load || retire_store) |=>
    completion_type_code == ($past(retire_load) ? 3'h2 : 3'h3)) else $error("load store code wrong");
  AST_PLAIN: assert property (plain && !sync_request |=> completion_type_code inside {3'h1, 3'h4})
    else $error("plain code wrong");
  AST_SYNC: assert property (plain && sync_request |=> completion_type_code == 3'h4)
    else $error("sync code wrong");
  AST_HOLD: assert property (stall_active |=> $stable(completion_type_code))
    else $error("code moved during stall");
  AST_STALL_END: assert property ($rose(stall_active) |-> ##[1:40] !stall_active)
    else $error("stall never ends");
  AST_RDATA: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved");
  AST_SUBSET: assert property (cfg_rd && cfg_addr == 2'h1 |=> cfg_rdata == {25'h0, IMPL_SUBSET, 5'h0})
    else $error("subset field wrong");
endmodule
bind ptc_trace_core ptc_trace_core_chk #(.IMPL_SUBSET(IMPL_SUBSET)) u_ptc_trace_core_chk (
  .clk(clk), .rst_b(rst_b), .retire_valid(retire_valid), .retire_killed(retire_killed),
  .retire_load(retire_load), .retire_store(retire_store), .retire_taken(retire_taken),
  .retire_reg_jump(retire_reg_jump), .retire_cond(retire_cond), .retire_exc(retire_exc),
  .retire_exception_return(retire_exception_return), .sync_request(sync_request), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .feature_flags_word(feature_flags_word),
  .completion_type_code(completion_type_code), .stall_active(stall_active));

// [bench/ptc_probe_model.sv]
// Probe-side receiver that rebuilds trace words from probe data slices.
module ptc_probe_model (
  input  wire        clk,         // Core clock.
  input  wire        rst_b,       // Reset, active low.
  input  wire [1:0]  pins,        // Pin count select.
  input  wire [15:0] probe_data,  // Probe data pins.
  input  wire        probe_valid, // Slice strobe.
  output reg  [31:0] word,        // Rebuilt word.
  output reg         got          // Word complete.
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [2:0] cnt;
  wire [2:0] last = (pins == 2'h0) ? 3'h7 : (pins == 2'h1) ? 3'h3 : 3'h1;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 3'h0;
      word <= 32'h0;
      got  <= 1'b0;
    end else begin
      got <= probe_valid && cnt == last;
      if (probe_valid) begin
        cnt <= (cnt == last) ? 3'h0 : cnt + 3'h1;
        // The low slice comes first, so each slice enters at the top and shifts down.
        case (pins)
          2'h0: word <= {probe_data[3:0], word[31:4]};
          2'h1: word <= {probe_data[7:0], word[31:8]};
          default: word <= {probe_data, word[31:16]};
        endcase
      end
    end
  end
endmodule

// [bench/ptc_trace_core_tb.sv]
// Self-checking bench for the program trace capture core.
module ptc_trace_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg          clk = 1'b0;
  reg          rst_b = 1'b0;
  reg  [9:0]   ev = 10'h0;
  reg  [31:0]  retire_pc = 32'h0;
  reg          cfg_wr = 1'b0;
  reg          cfg_rd = 1'b0;
  reg  [1:0]   cfg_addr = 2'h0;
  reg  [31:0]  cfg_wdata = 32'h0;
  reg  [1:0]   pins = 2'h0;
  wire [31:0]  cfg_rdata, feature_flags_word, word;
  wire [2:0]   completion_type_code;
  wire [15:0]  probe_data;
  wire         stall_active, probe_valid, got;
  int          err_count = 0, tests_run = 0, cycles = 0, nsync = 0;
  logic [31:0] exp_q[$];
  logic [31:0] d;
  logic [2:0]  pend = 3'h0;
  logic        pend_v = 1'b0, count_sync = 1'b0;
  // Event bits: sync, valid, killed, load, store, taken, reg jump, cond, exc, exception_return.
  logic [9:0]  seq [12] = '{10'h300, 10'h100, 10'h140, 10'h120, 10'h180, 10'h000,
                            10'h110, 10'h148, 10'h122, 10'h101, 10'h144, 10'h100};
  ptc_trace_core #(.SYNC_PERIOD(16'h0004)) u_ptc_trace_core (
    .clk(clk), .rst_b(rst_b), .retire_valid(ev[8]), .retire_killed(ev[7]), .retire_load(ev[6]),
    .retire_store(ev[5]), .retire_taken(ev[4]), .retire_reg_jump(ev[3]), .retire_cond(ev[2]),
    .retire_exc(ev[1]), .retire_exception_return(ev[0]), .sync_request(ev[9]), .retire_pc(retire_pc),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .feature_flags_word(feature_flags_word),
    .completion_type_code(completion_type_code), .stall_active(stall_active),
    .probe_data(probe_data), .probe_valid(probe_valid));
  ptc_probe_model u_ptc_probe_model (.clk(clk), .rst_b(rst_b), .pins(pins),
    .probe_data(probe_data), .probe_valid(probe_valid), .word(word), .got(got));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [31:0] v);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(posedge clk);
    v = cfg_rdata;
  endtask
  function automatic logic [2:0] code_of(input logic [9:0] e);
    if (!e[8] || e[7]) return 3'h0;
    if (|e[4:0]) return e[5] ? 3'h7 : (e[6] ? 3'h6 : 3'h5);
    if (e[6]) return 3'h2;
    if (e[5]) return 3'h3;
    return e[9] ? 3'h4 : 3'h1;
  endfunction
  // A request stands until an edge sees no stall; the previous code is judged at that edge.
  task automatic send(input logic [9:0] e, input logic [31:0] pc);
    logic [2:0] c;
    ev <= e;
    retire_pc <= pc;
    @(posedge clk);
    while (stall_active === 1'b1) @(posedge clk);
    if (pend_v && count_sync) nsync += (completion_type_code === 3'h4);
    else if (pend_v) chk(completion_type_code, pend);
    c = code_of(e);
    pend = c;
    pend_v = 1'b1;
    if (c != 3'h0) exp_q.push_back({c, (e[3] | e[1] | e[0] | c == 3'h4) ? pc[28:0] : 29'h0});
  endtask
  task automatic flush;
    send(10'h0, 32'h0);
    pend_v = 1'b0;
  endtask
  task automatic mem_check;
    logic [31:0] st, w;
    int n;
    wr(2'h0, 32'h0);
    wr(2'h2, 32'h0);
    rd(2'h3, st);
    n = st[5:0];
    for (int i = 0; i < n; i++) begin
      rd(2'h2, w);
      if (w[31:29] != 3'h0) chk(w, exp_q.size() ? exp_q.pop_front() : 32'hx);
    end
    chk(exp_q.size(), 0);
  endtask
  always @(posedge clk) if (got && word[31:29] != 3'h0) chk(word, exp_q.size() ? exp_q.pop_front() : 32'hx);
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk(feature_flags_word, 32'h1);
    rd(2'h1, d);
    chk(d, 32'h60);
    wr(2'h1, 32'h0);
    rd(2'h1, d);
    chk(d, 32'h60);
    $display("test identity done");
    wr(2'h0, 32'h1);
    rd(2'h2, d);
    chk(d, 32'h0);
    foreach (seq[i]) send(seq[i], 32'hf000_0000 + 32'h40 * i);
    flush();
    mem_check();
    $display("test codes to memory done");
    wr(2'h0, 32'h1);
    send(10'h300, 32'h0);
    count_sync = 1'b1;
    repeat (8) send(10'h100, 32'h0);
    flush();
    count_sync = 1'b0;
    chk(nsync >= 2 && nsync <= 3, 1);
    exp_q.delete();
    wr(2'h0, 32'h0);
    $display("test periodic sync done");
    for (int p = 0; p < 3; p++) begin
      pins <= p[1:0];
      wr(2'h0, {28'h0, p[1:0], 2'h3});
      foreach (seq[i]) send(seq[i], 32'h2000_0000 + 32'h100 * i);
      flush();
      for (int k = 0; k < 500 && exp_q.size() != 0; k++) @(posedge clk);
      chk(exp_q.size(), 0);
      wr(2'h0, 32'h0);
    end
    $display("test probe widths done");
    test_done();
  end
endmodule
